/* File: hdl/bips_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bips_defs.svh"
module bips_sequencer #(
  parameter int CNT_W = `BIPS_CNT_W,
  parameter logic [CNT_W-1:0] INSERT_CYC = CNT_W'(`BIPS_INSERT_CYC),
  parameter logic [CNT_W-1:0] HARD_RESET_CYC = CNT_W'(`BIPS_HARD_RESET_CYC),
  parameter logic [CNT_W-1:0] RELEASE_CYC = CNT_W'(`BIPS_RELEASE_CYC),
  parameter logic [CNT_W-1:0] WARN_CYC = CNT_W'(`BIPS_WARN_CYC),
  parameter logic [CNT_W-1:0] TRIP_CYC = CNT_W'(`BIPS_TRIP_CYC)
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic connect_sense_a_n_in,
  input wire logic connect_sense_b_n_in,
  input wire logic reset_request_n_in,
  input wire logic low_supply_input_ok_in,
  input wire logic high_supply_input_ok_in,
  input wire logic low_supply_above_in,
  input wire logic low_supply_output_below_trip_in,
  input wire logic high_supply_output_below_trip_in,
  input wire logic low_breaker_sense_in,
  input wire logic high_breaker_sense_in,
  output logic power_good_out,
  output logic reset_n_out,
  output logic fault_n_out,
  output logic bus_disable_out,
  output logic charge_pump_on_out,
  output logic high_gate_drive_out,
  output logic low_gate_drive_out,
  output logic gate_pulldown_out
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  localparam int NSYNC = 10;
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] meta;
  logic [NSYNC-1:0] sync;
  logic [NSYNC-1:0] next_meta;
  logic [NSYNC-1:0] next_sync;
  assign raw = {connect_sense_a_n_in, connect_sense_b_n_in, reset_request_n_in, low_supply_input_ok_in,
                high_supply_input_ok_in, low_supply_above_in, low_supply_output_below_trip_in,
                high_supply_output_below_trip_in, low_breaker_sense_in, high_breaker_sense_in};
  always_comb begin
    next_meta = raw;
    next_sync = meta;
  end
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      meta <= '0;
      sync <= '0;
    end else begin
      meta <= next_meta;
      sync <= next_sync;
    end
  end
  logic con_a_n;
  logic con_b_n;
  logic req_n;
  logic lo_ok;
  logic hi_ok;
  logic above;
  logic lo_below;
  logic hi_below;
  logic lo_brk;
  logic hi_brk;
  assign {con_a_n, con_b_n, req_n, lo_ok, hi_ok, above, lo_below, hi_below, lo_brk, hi_brk} = sync;

  logic uvlo_ok;
  logic inserted;
  assign uvlo_ok = lo_ok && hi_ok;
  assign inserted = !con_a_n && !con_b_n;

  // ----------------------------------------
  // Interval qualifiers
  // ----------------------------------------
  localparam int NQ = 5;
  logic [NQ-1:0] q_cond;
  logic [NQ-1:0] q_done;
  logic [CNT_W-1:0] q_limit [NQ];
  logic power_good;
  assign q_cond[0] = inserted && uvlo_ok;
  assign q_cond[1] = !req_n;
  assign q_cond[2] = power_good && !reset_n_out && inserted && req_n && uvlo_ok;
  assign q_cond[3] = lo_brk;
  assign q_cond[4] = hi_brk;
  assign q_limit[0] = INSERT_CYC;
  assign q_limit[1] = HARD_RESET_CYC;
  assign q_limit[2] = RELEASE_CYC;
  assign q_limit[3] = TRIP_CYC;
  assign q_limit[4] = TRIP_CYC;
  genvar gi;
  generate
    for (gi = 0; gi < NQ; gi++) begin : g_qual
      bips_qualifier #(.CNT_W(CNT_W)) u_qual (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .cond_in(q_cond[gi]),
        .limit_in(q_limit[gi]),
        .done_out(q_done[gi])
      );
    end
  endgenerate
  logic insert_done;
  logic hard_reset;
  logic release_done;
  logic trip_now;
  assign insert_done = q_done[0];
  assign hard_reset = q_done[1];
  assign release_done = q_done[2];
  assign trip_now = q_done[3] || q_done[4];

  // ----------------------------------------
  // Sequencer state, trip latch and warning timer
  // ----------------------------------------
  bips_pkg::bips_state_t state;
  bips_pkg::bips_state_t next_state;
  logic tripped;
  logic next_tripped;
  logic [CNT_W-1:0] warn_cnt;
  logic [CNT_W-1:0] next_warn_cnt;
  logic pumps;
  logic next_reset_n;

  always_comb begin
    next_state = state;
    case (state)
      bips_pkg::BIPS_OFF: begin
        // The debounce flag lags its condition by a cycle, so the live levels are checked too.
        if (insert_done && inserted && uvlo_ok && req_n && !tripped) begin
          next_state = bips_pkg::BIPS_ON;
        end
      end
      bips_pkg::BIPS_ON: begin
        if (!inserted || !uvlo_ok || hard_reset || trip_now || tripped) begin
          next_state = bips_pkg::BIPS_DOWN;
        end
      end
      bips_pkg::BIPS_DOWN: begin
        // A hard reset must also see both outputs discharged before the next ramp.
        if (req_n && lo_below && hi_below) begin
          next_state = bips_pkg::BIPS_OFF;
        end
      end
      default: next_state = bips_pkg::BIPS_DOWN;
    endcase
  end

  // While the pumps run (state BIPS_ON), the trip wins over a clear arriving in the same cycle, so an overcurrent then is never lost.
  always_comb begin
    next_tripped = tripped;
    if (!req_n || !uvlo_ok) begin
      next_tripped = 1'b0;
    end
    if (trip_now && pumps) begin
      next_tripped = 1'b1;
    end
  end

  assign pumps = state == bips_pkg::BIPS_ON;
  // Power-good is a plain follower; the 200 ms and 32 us windows filter only reset.
  assign power_good = above && !tripped && pumps;

  always_comb begin
    next_warn_cnt = '0;
    if (!power_good && reset_n_out) begin
      next_warn_cnt = warn_cnt;
      if (warn_cnt < WARN_CYC) begin
        next_warn_cnt = warn_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_comb begin
    next_reset_n = reset_n_out;
    if (!inserted || !req_n || !uvlo_ok || tripped && warn_cnt >= WARN_CYC) begin
      next_reset_n = 1'b0;
    end else if (reset_n_out && !power_good) begin
      if (warn_cnt >= WARN_CYC) begin
        next_reset_n = 1'b0;
      end
    end else if (!reset_n_out && release_done) begin
      next_reset_n = 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state <= bips_pkg::BIPS_OFF;
      tripped <= 1'b0;
      warn_cnt <= '0;
    end else begin
      state <= next_state;
      tripped <= next_tripped;
      warn_cnt <= next_warn_cnt;
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      power_good_out <= 1'b0;
      reset_n_out <= 1'b0;
      fault_n_out <= 1'b1;
      bus_disable_out <= 1'b1;
      charge_pump_on_out <= 1'b0;
      high_gate_drive_out <= 1'b0;
      low_gate_drive_out <= 1'b0;
      gate_pulldown_out <= 1'b1;
    end else begin
      power_good_out <= power_good;
      reset_n_out <= next_reset_n;
      fault_n_out <= !next_tripped;
      bus_disable_out <= !next_reset_n;
      charge_pump_on_out <= next_state == bips_pkg::BIPS_ON;
      high_gate_drive_out <= next_state == bips_pkg::BIPS_ON;
      low_gate_drive_out <= next_state == bips_pkg::BIPS_ON;
      gate_pulldown_out <= next_state != bips_pkg::BIPS_ON;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic [CNT_W-1:0] brk_run;
  logic [CNT_W-1:0] next_brk_run;
  logic [CNT_W-1:0] pg_run;
  logic [CNT_W-1:0] next_pg_run;
  // Run lengths feed only the assertions, so a long interval needs no long repetition.
  always_comb begin
    next_brk_run = '0;
    next_pg_run = '0;
    if (lo_brk || hi_brk) begin
      next_brk_run = brk_run;
      if (brk_run <= TRIP_CYC) begin
        next_brk_run = brk_run + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
    if (power_good) begin
      next_pg_run = pg_run;
      if (pg_run <= RELEASE_CYC) begin
        next_pg_run = pg_run + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      brk_run <= '0;
      pg_run <= '0;
    end else begin
      brk_run <= next_brk_run;
      pg_run <= next_pg_run;
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  a_pump_gate_match: assert property (
    charge_pump_on_out == high_gate_drive_out && high_gate_drive_out == low_gate_drive_out)
    else $error("Pump indicator and gate drives disagree.");
  a_pulldown_off: assert property (gate_pulldown_out != high_gate_drive_out)
    else $error("Pull-down and gate drive overlap.");
  a_trip_gates: assert property (trip_now && pumps |=> !high_gate_drive_out && !low_gate_drive_out)
    else $error("Gates not dropped on trip.");
  a_trip_fault: assert property ($rose(tripped) |=> !fault_n_out && !power_good_out)
    else $error("Fault or power-good not dropped on trip.");
  a_trip_fault_low: assert property (trip_now && pumps |=> !fault_n_out)
    else $error("Fault not raised on trip.");
  a_breaker_filter: assert property (trip_now |-> brk_run > TRIP_CYC)
    else $error("Breaker tripped on a short pulse.");
  a_clear_trip: assert property (!req_n && !trip_now |=> !tripped)
    else $error("Trip not cleared by reset request.");
  a_uvlo_off: assert property (!uvlo_ok |=> !charge_pump_on_out)
    else $error("Pumps on under lockout.");
  a_sense_off: assert property (!inserted |=> !charge_pump_on_out)
    else $error("Pumps on without insertion.");
  a_removal_disable: assert property (!inserted |=> bus_disable_out)
    else $error("Bus not disabled on removal.");
  a_pg_follow: assert property (pumps && !tripped |=> power_good_out == $past(above))
    else $error("Power-good does not follow monitor.");
  a_release_delay: assert property ($rose(reset_n_out) |-> $past(pg_run) > RELEASE_CYC)
    else $error("Reset released before the power-good interval.");
  a_reset_cond: assert property (!req_n |=> !reset_n_out)
    else $error("Reset not asserted on request.");
  a_no_up_req: assert property (!req_n |=> !$rose(charge_pump_on_out))
    else $error("Power-up while request low.");
  c_power_up: cover property ($rose(charge_pump_on_out));
  c_reset_release: cover property ($rose(reset_n_out));
  c_trip: cover property ($rose(tripped));
  c_hard_reset: cover property ($rose(hard_reset));
  c_trip_clear: cover property ($fell(tripped));
endmodule
`default_nettype wire

/* File: hdl/bips_defs.svh */
`ifndef BIPS_DEFS_SVH
`define BIPS_DEFS_SVH

// ----------------------------------------
// Timing figures and derived cycle counts
// ----------------------------------------
`define BIPS_CLK_MHZ 100
`define BIPS_INSERT_MS 20
`define BIPS_HARD_RESET_MS 20
`define BIPS_RELEASE_MS 200
`define BIPS_WARN_US 32
`define BIPS_TRIP_US 20
`define BIPS_INSERT_CYC (`BIPS_INSERT_MS * 1000 * `BIPS_CLK_MHZ)
`define BIPS_HARD_RESET_CYC (`BIPS_HARD_RESET_MS * 1000 * `BIPS_CLK_MHZ)
`define BIPS_RELEASE_CYC (`BIPS_RELEASE_MS * 1000 * `BIPS_CLK_MHZ)
`define BIPS_WARN_CYC (`BIPS_WARN_US * `BIPS_CLK_MHZ)
`define BIPS_TRIP_CYC (`BIPS_TRIP_US * `BIPS_CLK_MHZ)
`define BIPS_CNT_W 32

`endif

/* File: hdl/bips_pkg.sv */
package bips_pkg;
  typedef enum logic [3:0] {
    BIPS_OFF = 4'h1,
    BIPS_WAIT = 4'h2,
    BIPS_ON = 4'h4,
    BIPS_DOWN = 4'h8
  } bips_state_t;
endpackage

/* File: hdl/bips_qualifier.sv */
`timescale 1ns/1ps
`default_nettype none
module bips_qualifier #(
  parameter int CNT_W = 32
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic cond_in,
  input wire logic [CNT_W-1:0] limit_in,
  output logic done_out
);
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic next_done;

  // The count restarts whenever the condition breaks, so only an unbroken run qualifies.
  always_comb begin
    next_count = count;
    next_done = 1'b0;
    if (!cond_in) begin
      next_count = '0;
    end else if (count >= limit_in) begin
      next_done = 1'b1;
    end else begin
      next_count = count + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      count <= '0;
      done_out <= 1'b0;
    end else begin
      count <= next_count;
      done_out <= next_done;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/bips_supply_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Board supply outputs behind the pass transistors
// ----------------------------------------
// Levels ramp over eight cycles, so power-good and the trip level lag the gates.
// A slow discharge is held off by slow_in to mimic a heavily loaded board.
module bips_supply_model (
  input wire logic clock_in,
  input wire logic lo_gate_in,
  input wire logic hi_gate_in,
  input wire logic dip_in,
  input wire logic slow_in,
  output logic lo_above_out,
  output logic lo_below_out,
  output logic hi_below_out
);
  logic [3:0] lo_lvl = 4'h0;
  logic [3:0] hi_lvl = 4'h0;
  always @(posedge clock_in) begin
    if (lo_gate_in && lo_lvl != 4'h8) lo_lvl <= lo_lvl + 4'h1;
    else if (!lo_gate_in && !slow_in && lo_lvl != 4'h0) lo_lvl <= lo_lvl - 4'h1;
    if (hi_gate_in && hi_lvl != 4'h8) hi_lvl <= hi_lvl + 4'h1;
    else if (!hi_gate_in && !slow_in && hi_lvl != 4'h0) hi_lvl <= hi_lvl - 4'h1;
  end
  assign lo_above_out = (lo_lvl == 4'h8) && !dip_in;
  assign lo_below_out = (lo_lvl == 4'h0);
  assign hi_below_out = (hi_lvl == 4'h0);
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Bench top
// ----------------------------------------
// Intervals are shortened so that the whole run stays near one thousand cycles.
module tb_top;
  localparam int INS = 40, HRD = 40, REL = 60, WRN = 20, TRP = 10;
  logic clock_in = 1'b0, rst_n = 1'b0, sa_n = 1'b1, sb_n = 1'b1, req_n = 1'b1;
  logic lo_ok = 1'b1, hi_ok = 1'b1, lo_brk = 1'b0, hi_brk = 1'b0, dip = 1'b0, slow = 1'b0;
  logic lo_above, lo_below, hi_below, pg, rst_o_n, fault_n, bus_dis, charge_pump_on, hi_gate, lo_gate, pulldn;
  wire logic [7:0] obs = {pulldn, bus_dis, lo_gate, hi_gate, fault_n, rst_o_n, pg, charge_pump_on};
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  initial begin
    forever #5 clock_in = ~clock_in;
  end
  bips_sequencer #(.INSERT_CYC(INS), .HARD_RESET_CYC(HRD), .RELEASE_CYC(REL), .WARN_CYC(WRN),
    .TRIP_CYC(TRP)) uut (.clock_in(clock_in), .rst_n_in(rst_n), .connect_sense_a_n_in(sa_n),
    .connect_sense_b_n_in(sb_n), .reset_request_n_in(req_n), .low_supply_input_ok_in(lo_ok),
    .high_supply_input_ok_in(hi_ok), .low_supply_above_in(lo_above), .low_supply_output_below_trip_in(lo_below),
    .high_supply_output_below_trip_in(hi_below), .low_breaker_sense_in(lo_brk), .high_breaker_sense_in(hi_brk),
    .power_good_out(pg), .reset_n_out(rst_o_n), .fault_n_out(fault_n), .bus_disable_out(bus_dis),
    .charge_pump_on_out(charge_pump_on), .high_gate_drive_out(hi_gate), .low_gate_drive_out(lo_gate),
    .gate_pulldown_out(pulldn));
  bips_supply_model model (.clock_in(clock_in), .lo_gate_in(lo_gate), .hi_gate_in(hi_gate), .dip_in(dip),
    .slow_in(slow), .lo_above_out(lo_above), .lo_below_out(lo_below), .hi_below_out(hi_below));
  task automatic chk(input string nm, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %b, seen %b", nm, exp, got);
    end
  endtask
  task automatic reach(input string nm, input int s, input logic v, input int lim);
    int n;
    n = 0;
    while (obs[s] !== v && n < lim) begin
      @(negedge clock_in);
      n++;
    end
    chk(nm, v, obs[s]);
  endtask
  task automatic stays(input string nm, input int s, input logic v, input int c);
    logic ok;
    ok = 1'b1;
    repeat (c) begin
      @(negedge clock_in);
      if (obs[s] !== v) ok = 1'b0;
    end
    chk(nm, 1'b1, ok);
  endtask
  task automatic summarize;
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic t_power_up;
    chk("reset_n", 1'b0, rst_o_n);
    chk("bus_disable", 1'b1, bus_dis);
    @(posedge clock_in) sa_n <= 1'b0;
    @(posedge clock_in) sb_n <= 1'b0;
    stays("gates held", 4, 1'b0, INS / 2);
    stays("pump held", 0, 1'b0, INS / 2 - 4);
    reach("charge_pump_on", 0, 1'b1, 20);
    chk("low_gate_drive", 1'b1, lo_gate);
    reach("power_good", 1, 1'b1, 20);
    stays("reset_n held", 2, 1'b0, REL - 4);
    reach("reset_n", 2, 1'b1, 10);
    chk("bus_disable", 1'b0, bus_dis);
  endtask
  task automatic t_dip;
    @(posedge clock_in) dip <= 1'b1;
    reach("power_good", 1, 1'b0, 6);
    @(posedge clock_in) dip <= 1'b0;
    stays("reset_n kept", 2, 1'b1, WRN + 10);
    @(posedge clock_in) dip <= 1'b1;
    stays("reset_n warn", 2, 1'b1, WRN - 4);
    reach("reset_n", 2, 1'b0, 10);
    @(posedge clock_in) dip <= 1'b0;
    stays("reset_n short", 2, 1'b0, 20);
    @(posedge clock_in) dip <= 1'b1;
    stays("reset_n low", 2, 1'b0, REL);
    @(posedge clock_in) dip <= 1'b0;
    reach("reset_n", 2, 1'b1, REL + 10);
  endtask
  task automatic t_hard_reset;
    @(posedge clock_in) slow <= 1'b1;
    @(posedge clock_in) req_n <= 1'b0;
    stays("pump before hard reset", 0, 1'b1, HRD - 4);
    reach("charge_pump_on", 0, 1'b0, 10);
    chk("gate_pulldown", 1'b1, pulldn);
    reach("reset_n", 2, 1'b0, 4);
    stays("pump while request", 0, 1'b0, INS + 10);
    @(posedge clock_in) req_n <= 1'b1;
    stays("pump until discharged", 0, 1'b0, INS + 10);
    @(posedge clock_in) slow <= 1'b0;
    reach("charge_pump_on", 0, 1'b1, INS + 40);
    reach("reset_n", 2, 1'b1, REL + 40);
  endtask
  task automatic t_trip;
    @(posedge clock_in) lo_brk <= 1'b1;
    repeat (5) @(posedge clock_in);
    lo_brk <= 1'b0;
    @(posedge clock_in) lo_brk <= 1'b1;
    repeat (5) @(posedge clock_in);
    lo_brk <= 1'b0;
    stays("fault_n on short pulses", 3, 1'b1, 20);
    @(posedge clock_in) hi_brk <= 1'b1;
    reach("fault_n", 3, 1'b0, TRP + 6);
    reach("power_good", 1, 1'b0, 1);
    reach("high_gate_drive", 4, 1'b0, 1);
    reach("low_gate_drive", 5, 1'b0, 1);
    stays("reset_n after trip", 2, 1'b1, WRN - 6);
    reach("reset_n", 2, 1'b0, 10);
    @(posedge clock_in) hi_brk <= 1'b0;
    stays("trip latched", 3, 1'b0, INS + 20);
    chk("charge_pump_on", 1'b0, charge_pump_on);
    @(posedge clock_in) req_n <= 1'b0;
    reach("fault_n", 3, 1'b1, 6);
    stays("pump while request", 0, 1'b0, HRD + 10);
    @(posedge clock_in) req_n <= 1'b1;
    reach("charge_pump_on", 0, 1'b1, INS + 40);
    reach("reset_n", 2, 1'b1, REL + 40);
  endtask
  task automatic t_remove_lockout;
    @(posedge clock_in) sa_n <= 1'b1;
    reach("charge_pump_on", 0, 1'b0, 4);
    reach("reset_n", 2, 1'b0, 4);
    reach("bus_disable", 6, 1'b1, 4);
    @(posedge clock_in) sa_n <= 1'b0;
    reach("charge_pump_on", 0, 1'b1, INS + 40);
    @(posedge clock_in) lo_ok <= 1'b0;
    reach("charge_pump_on", 0, 1'b0, 6);
    reach("reset_n", 2, 1'b0, 4);
    @(posedge clock_in) lo_ok <= 1'b1;
    @(posedge clock_in) hi_ok <= 1'b0;
    stays("pump in lockout", 0, 1'b0, INS + 20);
    @(posedge clock_in) hi_ok <= 1'b1;
    reach("charge_pump_on", 0, 1'b1, INS + 40);
  endtask
  initial begin
    repeat (16) @(posedge clock_in);
    rst_n <= 1'b1;
    @(negedge clock_in);
    t_power_up();
    t_dip();
    t_hard_reset();
    t_trip();
    t_remove_lockout();
    summarize();
  end
endmodule
`default_nettype wire
